// ===== design/digital_rx_error_status.sv
// receiver preamble and error status register bank
// Operation
// - outside subframe non-audio, 0x17 shows preamble D low byte with burst non-audio, else 0.
// - in subframe non-audio, 0x17 carries the channel B preamble C high byte.
// - bit 7 of 0x18 mirrors the received validity bit.
// - bit 5 follows non-audio; re-raises only on a change of state or type.
// - bit 4 follows burst non-audio; raises an event only on a change.
// - bit 3 is set on a checksum failure and held until 0x18 is read.
// - bit 2 follows stream absence; a read re-arms, event only on change.
// - bit 1 is set on a biphase or parity error and held until read.
// - bit 0 follows pll lock; event only when lock state changes.
`timescale 1ns/10ps
`default_nettype none
module digital_rx_error_status #(
    parameter int TYPE_W = rx_status_pkg::TYPE_W_DEFAULT
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire rx_status_pkg::front_s front_in,
    input wire logic [TYPE_W-1:0] nonaudio_type_in,
    input wire rx_status_pkg::reg_req_s req_in,
    output logic [rx_status_pkg::DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    output logic [rx_status_pkg::DATA_W-1:0] irq_pending_out
);
    localparam int DW = rx_status_pkg::DATA_W;

    if (TYPE_W < 1) begin : g_bad_type_w
        $error("TYPE_W must be at least one");
    end

    function automatic logic addr_hit(
        input logic [rx_status_pkg::ADDR_W-1:0] addr,
        input logic [rx_status_pkg::ADDR_W-1:0] target
    );
        return addr == target;
    endfunction

    logic status_read;
    logic preamble_read;
    logic [TYPE_W-1:0] type_q;
    logic type_change;
    logic [DW-1:0] cond;
    logic [DW-1:0] change;
    logic [DW-1:0] flags;
    logic [DW-1:0] pending;
    logic [DW-1:0] preamble_low_q;
    logic [DW-1:0] preamble_low_d;
    logic [DW-1:0] rd_data_q;
    logic [DW-1:0] rd_data_d;
    logic rd_valid_q;
    logic [DW-1:0] preamble_d_lo;
    logic [DW-1:0] preamble_c_hi;

    assign status_read = req_in.rd
        && addr_hit(req_in.addr, rx_status_pkg::RX_ERROR_STATUS_ADDR);
    assign preamble_read = req_in.rd
        && addr_hit(req_in.addr, rx_status_pkg::PREAMBLE_D_LOW_ADDR);

    assign preamble_d_lo =
        front_in.preamble_d[rx_status_pkg::BYTE_LO +: DW];
    assign preamble_c_hi =
        front_in.preamble_c_b[rx_status_pkg::BYTE_HI +: DW];

    // subframe mode takes precedence: the register is repurposed there
    always_comb begin
        if (front_in.subframe_nonaudio) begin
            preamble_low_d = preamble_c_hi;
        end else if (front_in.burst_nonaudio) begin
            preamble_low_d = preamble_d_lo;
        end else begin
            preamble_low_d = rx_status_pkg::ZERO_BYTE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            preamble_low_q <= rx_status_pkg::ZERO_BYTE;
        end else begin
            preamble_low_q <= preamble_low_d;
        end
    end

    // type tracked only while non-audio, so audio periods don't re-trigger
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            type_q <= '0;
        end else if (front_in.non_audio) begin
            type_q <= nonaudio_type_in;
        end
    end
    assign type_change = front_in.non_audio && (nonaudio_type_in != type_q);

    always_comb begin
        cond = rx_status_pkg::ZERO_BYTE;
        change = rx_status_pkg::ZERO_BYTE;
        cond[rx_status_pkg::BIT_VALIDITY] =
            front_in.received_validity_flag;
        cond[rx_status_pkg::BIT_EMPHASIS] = front_in.emphasis;
        cond[rx_status_pkg::BIT_NON_AUDIO] = front_in.non_audio;
        change[rx_status_pkg::BIT_NON_AUDIO] = type_change;
        cond[rx_status_pkg::BIT_BURST] = front_in.burst_nonaudio;
        cond[rx_status_pkg::BIT_CHECKSUM] =
            front_in.status_checksum_error;
        cond[rx_status_pkg::BIT_ABSENT] = front_in.stream_absent_flag;
        cond[rx_status_pkg::BIT_CODING] =
            front_in.biphase_error || front_in.parity_error;
        cond[rx_status_pkg::BIT_LOCK] = front_in.pll_lock;
    end

    for (genvar i = 0; i < DW; i++) begin : g_flag
        status_flag #(
            .STICKY(rx_status_pkg::STICKY_MASK[i])
        ) u_flag (
            .ref_clk_in(ref_clk_in),
            .rst_n_in(rst_n_in),
            .cond_in(cond[i]),
            .change_in(change[i]),
            .clear_in(status_read),
            .flag_out(flags[i]),
            .pending_out(pending[i])
        );
    end

    // read data taken before the clear lands at the same edge
    always_comb begin
        if (status_read) begin
            rd_data_d = flags;
        end else if (preamble_read) begin
            rd_data_d = preamble_low_q;
        end else begin
            rd_data_d = rx_status_pkg::ZERO_BYTE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rd_data_q <= rx_status_pkg::ZERO_BYTE;
        end else if (req_in.rd) begin
            rd_data_q <= rd_data_d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= req_in.rd;
        end
    end

    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;
    assign irq_pending_out = pending;

    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic validity_in;
    logic emphasis_in;
    logic absent_in;
    logic burst_in;
    logic lock_in;
    logic coding_in;
    logic checksum_in;
    assign validity_in = front_in.received_validity_flag;
    assign emphasis_in = front_in.emphasis;
    assign absent_in = front_in.stream_absent_flag;
    assign burst_in = front_in.burst_nonaudio;
    assign lock_in = front_in.pll_lock;
    assign coding_in = front_in.biphase_error || front_in.parity_error;
    assign checksum_in = front_in.status_checksum_error;

    a_preamble_zero_idle: assert property (
        !front_in.subframe_nonaudio && !burst_in
        |=> preamble_low_q == rx_status_pkg::ZERO_BYTE)
        else $error("preamble low not zero without burst");

    a_preamble_d_low: assert property (
        !front_in.subframe_nonaudio && burst_in
        |=> preamble_low_q == $past(preamble_d_lo))
        else $error("preamble low byte not shown");

    a_preamble_read_back: assert property (
        preamble_read |=> rd_valid_out && rd_data_out == $past(preamble_low_q))
        else $error("preamble read returns wrong byte");

    a_subframe_c_byte: assert property (
        front_in.subframe_nonaudio
        |=> preamble_low_q == $past(preamble_c_hi))
        else $error("subframe byte not carried");

    // start a cycle early so a read right after reset is not judged
    a_validity_mirror: assert property (
        1'b1 ##1 status_read ##1 1'b1 |->
            rd_data_out[rx_status_pkg::BIT_VALIDITY] == $past(validity_in, 2))
        else $error("validity bit not mirrored");

    a_validity_event: assert property (
        validity_in != flags[rx_status_pkg::BIT_VALIDITY]
        |=> pending[rx_status_pkg::BIT_VALIDITY])
        else $error("validity change raised no event");

    a_emphasis_rearm: assert property (
        status_read && emphasis_in && flags[rx_status_pkg::BIT_EMPHASIS]
        |=> flags[rx_status_pkg::BIT_EMPHASIS]
            && !pending[rx_status_pkg::BIT_EMPHASIS])
        else $error("emphasis not held or re-raised");

    a_emphasis_change: assert property (
        emphasis_in != flags[rx_status_pkg::BIT_EMPHASIS]
        |=> pending[rx_status_pkg::BIT_EMPHASIS]
            && flags[rx_status_pkg::BIT_EMPHASIS] == $past(emphasis_in))
        else $error("emphasis change missed");

    sequence s_type_shift;
        front_in.non_audio && (nonaudio_type_in != type_q);
    endsequence

    a_type_change_event: assert property (
        s_type_shift |=> pending[rx_status_pkg::BIT_NON_AUDIO])
        else $error("non-audio type change raised no event");

    a_nonaudio_quiet: assert property (
        status_read && !type_change
            && front_in.non_audio == flags[rx_status_pkg::BIT_NON_AUDIO]
        |=> !pending[rx_status_pkg::BIT_NON_AUDIO])
        else $error("non-audio re-raised without change");

    a_burst_state_hold: assert property (
        status_read && burst_in == flags[rx_status_pkg::BIT_BURST]
        |=> !pending[rx_status_pkg::BIT_BURST]
            && $stable(flags[rx_status_pkg::BIT_BURST]))
        else $error("burst flag not held across read");

    a_burst_change_event: assert property (
        burst_in != flags[rx_status_pkg::BIT_BURST]
        |=> pending[rx_status_pkg::BIT_BURST])
        else $error("burst change raised no event");

    sequence s_checksum_hit;
        checksum_in;
    endsequence

    sequence s_no_read3;
        (!status_read)[*3];
    endsequence

    a_checksum_held: assert property (
        s_checksum_hit ##1 s_no_read3 |-> flags[rx_status_pkg::BIT_CHECKSUM])
        else $error("checksum flag lost before read");

    a_checksum_wins: assert property (
        s_checksum_hit |=> flags[rx_status_pkg::BIT_CHECKSUM]
            && pending[rx_status_pkg::BIT_CHECKSUM])
        else $error("checksum error not set");

    a_coding_held: assert property (
        coding_in ##1 s_no_read3 |-> flags[rx_status_pkg::BIT_CODING])
        else $error("coding flag lost before read");

    a_absent_rearm: assert property (
        status_read && absent_in && flags[rx_status_pkg::BIT_ABSENT]
        |=> flags[rx_status_pkg::BIT_ABSENT]
            && !pending[rx_status_pkg::BIT_ABSENT])
        else $error("absence flag not re-armed");

    a_absent_change: assert property (
        absent_in != flags[rx_status_pkg::BIT_ABSENT]
        |=> pending[rx_status_pkg::BIT_ABSENT]
            && flags[rx_status_pkg::BIT_ABSENT] == $past(absent_in))
        else $error("absence change missed");

    a_coding_sticky: assert property (
        coding_in |=> flags[rx_status_pkg::BIT_CODING]
            && pending[rx_status_pkg::BIT_CODING])
        else $error("coding error not held");

    a_lock_follows: assert property (
        lock_in != flags[rx_status_pkg::BIT_LOCK]
        |=> flags[rx_status_pkg::BIT_LOCK] == $past(lock_in)
            && pending[rx_status_pkg::BIT_LOCK])
        else $error("lock state change not tracked");

    a_lock_quiet: assert property (
        status_read && lock_in == flags[rx_status_pkg::BIT_LOCK]
        |=> !pending[rx_status_pkg::BIT_LOCK]
            && $stable(flags[rx_status_pkg::BIT_LOCK]))
        else $error("lock flag not held across read");

    a_read_clears: assert property (
        status_read && !checksum_in && !coding_in
        |=> !flags[rx_status_pkg::BIT_CHECKSUM]
            && !flags[rx_status_pkg::BIT_CODING] && rd_valid_out)
        else $error("read did not clear held flags");

    a_read_reports: assert property (
        status_read |=> rd_data_out == $past(flags))
        else $error("read data not the pre-clear flags");

    a_valid_pulse: assert property (
        1'b1 |=> rd_valid_out == $past(req_in.rd))
        else $error("read valid not one cycle after strobe");

    a_read_data_hold: assert property (
        !req_in.rd |=> $stable(rd_data_out))
        else $error("read data changed without a read");

    a_unmapped_zero: assert property (
        req_in.rd && !status_read && !preamble_read
        |=> rd_data_out == rx_status_pkg::ZERO_BYTE)
        else $error("unmapped read not zero");

endmodule // digital_rx_error_status
`default_nettype wire

// ===== design/rx_status_pkg.sv
// constants and carriers for the receiver status register bank
package rx_status_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PREAMBLE_W = 16;
    localparam int TYPE_W_DEFAULT = 5;
    localparam logic [ADDR_W-1:0] PREAMBLE_D_LOW_ADDR = 7'h17;
    localparam logic [ADDR_W-1:0] RX_ERROR_STATUS_ADDR = 7'h18;
    localparam int BIT_VALIDITY = 7;
    localparam int BIT_EMPHASIS = 6;
    localparam int BIT_NON_AUDIO = 5;
    localparam int BIT_BURST = 4;
    localparam int BIT_CHECKSUM = 3;
    localparam int BIT_ABSENT = 2;
    localparam int BIT_CODING = 1;
    localparam int BIT_LOCK = 0;
    localparam int BYTE_LO = 0;
    localparam int BYTE_HI = 8;
    // held error flags; all others follow a live state
    localparam logic [DATA_W-1:0] STICKY_MASK = 8'h0A;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    typedef struct packed {
        logic received_validity_flag;
        logic emphasis;
        logic non_audio;
        logic burst_nonaudio;
        logic subframe_nonaudio;
        logic status_checksum_error;
        logic stream_absent_flag;
        logic biphase_error;
        logic parity_error;
        logic pll_lock;
        logic [PREAMBLE_W-1:0] preamble_d;
        logic [PREAMBLE_W-1:0] preamble_c_b;
    } front_s;

    typedef struct packed {
        logic rd;
        logic [ADDR_W-1:0] addr;
    } reg_req_s;
endpackage

// ===== design/status_flag.sv
// one status bit: held error flag or live state with change detect
`timescale 1ns/10ps
`default_nettype none
module status_flag #(
    parameter bit STICKY = 1'b0
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic cond_in,
    input wire logic change_in,
    input wire logic clear_in,
    output logic flag_out,
    output logic pending_out
);
    logic flag_q;
    logic pending_q;

    if (STICKY) begin : g_held
        // a hit in the clearing cycle wins over the read
        always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
                flag_q <= 1'b0;
            end else if (cond_in) begin
                flag_q <= 1'b1;
            end else if (clear_in) begin
                flag_q <= 1'b0;
            end
        end
        assign pending_q = flag_q;
    end else begin : g_state
        always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
                flag_q <= 1'b0;
            end else begin
                flag_q <= cond_in;
            end
        end
        // a change in the read cycle still re-arms the interrupt
        always_ff @(posedge ref_clk_in) begin
            if (!rst_n_in) begin
                pending_q <= 1'b0;
            end else if ((cond_in != flag_q) || change_in) begin
                pending_q <= 1'b1;
            end else if (clear_in) begin
                pending_q <= 1'b0;
            end
        end
    end

    assign flag_out = flag_q;
    assign pending_out = pending_q;
endmodule // status_flag
`default_nettype wire

// ===== bench/rx_front_model.sv
// far-side transmitter model driving the receiver front levels
`timescale 1ns/10ps
`default_nettype none
module rx_front_model (
    input wire logic ref_clk_in,
    output var rx_status_pkg::front_s front_out,
    output var logic [4:0] type_out
);
    // levels move just after an edge, as a real front end settles
    task automatic send(input rx_status_pkg::front_s f, input logic [4:0] t);
        @(posedge ref_clk_in);
        #1;
        front_out = f;
        type_out = t;
    endtask
    initial begin
        front_out = '0;
        type_out = 5'h00;
    end
endmodule // rx_front_model
`default_nettype wire

// ===== bench/tb_digital_rx_error_status.sv
// self-checking bench for the receiver status register bank
`timescale 1ns/10ps
`default_nettype none
module tb_digital_rx_error_status;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    rx_status_pkg::front_s front;
    logic [4:0] ntype;
    rx_status_pkg::reg_req_s req = '0;
    logic [7:0] rd_data, pend;
    logic rd_valid;
    int num_errors = 0;
    int total_checks = 0;
    int seed = 32'h4AF7;
    logic [7:0] flag_q, pend_q, data_q, pre_q;
    logic [4:0] type_q;
    logic valid_q;

    always #50 ref_clk_in = ~ref_clk_in;

    rx_front_model model (.ref_clk_in(ref_clk_in), .front_out(front),
        .type_out(ntype));
    digital_rx_error_status dut (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .front_in(front), .nonaudio_type_in(ntype),
        .req_in(req), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
        .irq_pending_out(pend));

    function automatic logic [7:0] live(rx_status_pkg::front_s f);
        return {f.received_validity_flag, f.emphasis, f.non_audio,
            f.burst_nonaudio, 1'b0, f.stream_absent_flag, 1'b0, f.pll_lock};
    endfunction
    function automatic logic [7:0] pre(rx_status_pkg::front_s f);
        if (f.subframe_nonaudio)
            return f.preamble_c_b[15:8];
        return f.burst_nonaudio ? f.preamble_d[7:0] : 8'h00;
    endfunction

    // reference of flags, events and read data, one edge at a time
    always @(posedge ref_clk_in) begin : ref_model
        logic rd18;
        logic [7:0] nf, chg;
        rd18 = req.rd && req.addr === 7'h18;
        nf = live(front);
        nf[3] = front.status_checksum_error | (flag_q[3] & !rd18);
        nf[1] = front.biphase_error | front.parity_error | (flag_q[1] & !rd18);
        chg = (nf ^ flag_q) & ~8'h0A;
        chg[5] = chg[5] | (front.non_audio && ntype !== type_q);
        if (!rst_n_in) begin
            flag_q <= 8'h00;
            pend_q <= 8'h00;
            data_q <= 8'h00;
            pre_q <= 8'h00;
            type_q <= ntype;
            valid_q <= 1'b0;
        end else begin
            valid_q <= req.rd;
            if (req.rd)
                data_q <= rd18 ? flag_q : (req.addr === 7'h17 ? pre_q : 8'h00);
            pend_q <= ((chg | (pend_q & {8{!rd18}})) & ~8'h0A) | (nf & 8'h0A);
            flag_q <= nf;
            pre_q <= pre(front);
            type_q <= ntype;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    always @(negedge ref_clk_in) begin
        if (rst_n_in) begin
            check(pend, pend_q);
            check({7'h00, rd_valid}, {7'h00, valid_q});
            if (valid_q)
                check(rd_data, data_q);
        end
    end

    task automatic step(input rx_status_pkg::front_s f, input logic [4:0] t,
        input logic rd, input logic [6:0] a);
        model.send(f, t);
        req.rd = rd;
        req.addr = a;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #1_000_000;
        num_errors++;
        stop_test();
    end

    initial begin : stim
        rx_status_pkg::front_s f;
        logic [63:0] flip;
        logic [4:0] t;
        logic [6:0] a;
        f = '0;
        t = 5'h00;
        repeat (16) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        // every preamble mode, with both words loaded
        for (int m = 0; m < 4; m++) begin
            f.subframe_nonaudio = m[1];
            f.burst_nonaudio = m[0];
            f.preamble_d = 16'hA5C3;
            f.preamble_c_b = 16'h3CE1;
            step(f, t, 1'b0, 7'h00);
            step(f, t, 1'b1, 7'h17);
            step(f, t, 1'b0, 7'h00);
        end
        // error arriving in the very read cycle must survive it
        f.status_checksum_error = 1'b1;
        f.parity_error = 1'b1;
        step(f, t, 1'b1, 7'h18);
        f.status_checksum_error = 1'b0;
        f.parity_error = 1'b0;
        step(f, t, 1'b1, 7'h18);
        step(f, t, 1'b1, 7'h18);
        step(f, t, 1'b1, 7'h7F);
        for (int i = 0; i < 3000; i++) begin
            flip = {$random(seed), $random(seed)} & {$random(seed),
                $random(seed)} & {$random(seed), $random(seed)};
            f = f ^ flip[41:0];
            t = t ^ (flip[46:42] & {5{flip[47]}});
            a = flip[49] ? 7'h18 : (flip[50] ? 7'h17 : 7'($random(seed)));
            step(f, t, 1'($random(seed)), a);
            if (i == 1500) begin
                rst_n_in = 1'b0;
                step(f, t, 1'b0, 7'h00);
                step(f, t, 1'b0, 7'h00);
                rst_n_in = 1'b1;
            end
        end
        step(f, t, 1'b0, 7'h00);
        step(f, t, 1'b0, 7'h00);
        stop_test();
    end
endmodule // tb_digital_rx_error_status
`default_nettype wire
